// ==== inc/pio_pkg.sv ====
// Constants for the mapped parallel port expander.
// Assumes a host with a multiplexed 16-bit address, 8-bit data external bus.
package pio_pkg;
  // Decode regions
  localparam logic [15:0] region_base = 16'hb000;
  localparam logic [15:0] region_mask = 16'hf000;
  localparam logic [15:0] port_space = 16'hb800;
  // Register addresses
  localparam logic [15:0] cmd_addr = 16'hb800;
  localparam logic [15:0] porta_addr = 16'hb801;
  localparam logic [15:0] portb_addr = 16'hb802;
  localparam logic [15:0] portc_addr = 16'hb803;
  // Command fields
  localparam int cmd_a_bit = 0;
  localparam int cmd_b_bit = 1;
  localparam int cmd_c_lo = 2;
  localparam logic [1:0] c_out_code = 2'h3;
  localparam logic [7:0] cmd_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  // Widths
  localparam int wide_w = 8;
  localparam int narrow_w = 6;
endpackage

// ==== inc/port_if.sv ====
// Carries one port's write, direction and pin signals between top and port.
// Assumes a single clock domain.
interface port_if #(parameter int W = 8);
  logic wr;
  logic [W-1:0] wdata;
  logic drive;
  logic [W-1:0] pin_in;
  logic [W-1:0] latch;
  logic [W-1:0] rd_val;
  modport port(input wr, input wdata, input drive, input pin_in, output latch, output rd_val);
  modport ctl(output wr, output wdata, output drive, output pin_in, input latch, input rd_val);
endinterface

// ==== design/pio_port.sv ====
// One parallel port: output latch plus synchronised pin sampling.
// Assumes write pulses are single-cycle, same clock domain.
module pio_port #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Port signals
  port_if.port p
);
  typedef struct packed {
    logic [W-1:0] latch;
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } port_st_t;
  port_st_t cur_ff;
  port_st_t nxt_st;

  // Latch written byte, double-sample the pins
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.s1 = p.pin_in;
    nxt_st.s2 = cur_ff.s1;
    if (p.wr) begin
      nxt_st.latch = p.wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign p.latch = cur_ff.latch;
  // Output port reads back its latch, input port reads the pins
  assign p.rd_val = p.drive ? cur_ff.latch : cur_ff.s2;
endmodule

// ==== design/pio_expander.sv ====
// Top of the mapped parallel port expander on a multiplexed host bus.
// Assumes address latch enable, read and write strobes arrive asynchronously
// and are much slower than the 100 MHz clock.
// Contract
// - Only accesses inside the region starting at b000 select the block.
// - Region addresses below b800 hit internal RAM, reserved and unused by the host.
// - The block offers two 8-bit ports and one 6-bit port, 22 lines in all.
// - Command bits 0 and 1 make ports A and B outputs; bits 3:2 equal 11 make port C output.
// - Command sits at b800, port A at b801, port B at b802, port C at b803.
// - A read of a port address returns that port's current value on the data bus.
// - A port write latches the byte and drives it on the pins when the port is output.
module pio_expander (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Host multiplexed bus
  input wire logic ale,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  input wire logic host_write_strobe_line_n,
  input wire logic host_read_strobe_line_n,
  // Port A pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic pa_oe,
  // Port B pins
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic pb_oe,
  // Six-bit port pins
  input wire logic [5:0] six_bit_port_in,
  output logic [5:0] six_bit_port_out,
  output logic six_bit_port_oe
);
  localparam int AW = pio_pkg::wide_w;
  localparam int CW = pio_pkg::narrow_w;

  typedef struct packed {
    logic [2:0] ale_s;   // [0] first stage, [1] second, [2] previous
    logic [2:0] wr_s;
    logic [2:0] rd_s;
    logic [15:0] addr_s1;
    logic [15:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic [15:0] addr;
    logic [7:0] cmd;
    logic [7:0] rdata;
    logic oe;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [5:0] narrow_pins;
    logic pa_oe;
    logic pb_oe;
    logic narrow_oe;
  } top_st_t;
  top_st_t cur_ff;
  top_st_t nxt_st;

  port_if #(.W(AW)) ia ();
  port_if #(.W(AW)) ib ();
  port_if #(.W(CW)) ic ();

  pio_port #(.W(AW)) u_pa (.clock(clock), .nrst(nrst), .p(ia));
  pio_port #(.W(AW)) u_pb (.clock(clock), .nrst(nrst), .p(ib));
  pio_port #(.W(CW)) u_pc (.clock(clock), .nrst(nrst), .p(ic));

  // Decode of the captured address
  logic in_region;
  logic hit_cmd;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic ale_fall;
  logic wr_rise;
  logic rd_act;
  logic dir_a;
  logic dir_b;
  logic dir_c;
  assign in_region = (cur_ff.addr & pio_pkg::region_mask) == pio_pkg::region_base;
  assign hit_cmd = in_region && cur_ff.addr == pio_pkg::cmd_addr;
  assign hit_a = in_region && cur_ff.addr == pio_pkg::porta_addr;
  assign hit_b = in_region && cur_ff.addr == pio_pkg::portb_addr;
  assign hit_c = in_region && cur_ff.addr == pio_pkg::portc_addr;
  // Address is held on ale falling; write takes effect as the strobe rises
  assign ale_fall = cur_ff.ale_s[2] && !cur_ff.ale_s[1];
  assign wr_rise = !cur_ff.wr_s[2] && cur_ff.wr_s[1];
  assign rd_act = !cur_ff.rd_s[1];
  assign dir_a = cur_ff.cmd[pio_pkg::cmd_a_bit];
  assign dir_b = cur_ff.cmd[pio_pkg::cmd_b_bit];
  assign dir_c = cur_ff.cmd[pio_pkg::cmd_c_lo +: 2] == pio_pkg::c_out_code;

  // Port interface wiring; pins are sampled inside each port
  always_comb begin
    ia.wr = wr_rise && hit_a;
    ib.wr = wr_rise && hit_b;
    ic.wr = wr_rise && hit_c;
    ia.wdata = cur_ff.data_s2;
    ib.wdata = cur_ff.data_s2;
    ic.wdata = cur_ff.data_s2[CW-1:0];
    ia.drive = dir_a;
    ib.drive = dir_b;
    ic.drive = dir_c;
    ia.pin_in = pa_in;
    ib.pin_in = pb_in;
    ic.pin_in = six_bit_port_in;
  end

  // Bus sync, address capture, command register, read mux, pin registers
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.ale_s = {cur_ff.ale_s[1:0], ale};
    nxt_st.wr_s = {cur_ff.wr_s[1:0], host_write_strobe_line_n};
    nxt_st.rd_s = {cur_ff.rd_s[1:0], host_read_strobe_line_n};
    nxt_st.addr_s1 = {addr_hi, ad_in};
    nxt_st.addr_s2 = cur_ff.addr_s1;
    nxt_st.data_s1 = ad_in;
    nxt_st.data_s2 = cur_ff.data_s1;
    if (ale_fall) begin
      nxt_st.addr = cur_ff.addr_s2;
    end
    // Command is write-only; RAM area below b800 is ignored
    if (wr_rise && hit_cmd) begin
      nxt_st.cmd = cur_ff.data_s2;
    end
    // Drive the bus only during a port read; the command reads nothing
    nxt_st.oe = rd_act && (hit_a || hit_b || hit_c);
    nxt_st.rdata = 8'h00;
    if (hit_a) begin
      nxt_st.rdata = ia.rd_val;
    end else if (hit_b) begin
      nxt_st.rdata = ib.rd_val;
    end else if (hit_c) begin
      nxt_st.rdata = {2'h0, ic.rd_val};
    end
    nxt_st.pa = ia.latch;
    nxt_st.pb = ib.latch;
    nxt_st.narrow_pins = ic.latch;
    nxt_st.pa_oe = dir_a;
    nxt_st.pb_oe = dir_b;
    nxt_st.narrow_oe = dir_c;
  end

  // Strobe syncs reset to idle-high so no false edge appears at release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.wr_s <= 3'h7;
      cur_ff.rd_s <= 3'h7;
      cur_ff.cmd <= pio_pkg::cmd_reset;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign ad_out = cur_ff.rdata;
  assign ad_oe = cur_ff.oe;
  assign pa_out = cur_ff.pa;
  assign pb_out = cur_ff.pb;
  assign six_bit_port_out = cur_ff.narrow_pins;
  assign pa_oe = cur_ff.pa_oe;
  assign pb_oe = cur_ff.pb_oe;
  assign six_bit_port_oe = cur_ff.narrow_oe;

  // Checks
  sequence cmd_wr_s;
    wr_rise && hit_cmd;
  endsequence
  cmd_write_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_wr_s |=> cur_ff.cmd == $past(cur_ff.data_s2)) else $error("command not stored");
  port_a_dir_a: assert property (@(posedge clock) disable iff (!nrst)
    cur_ff.cmd[0] |=> pa_oe) else $error("port a not driven");
  port_c_dir_a: assert property (@(posedge clock) disable iff (!nrst)
    (cur_ff.cmd[3:2] != 2'h3) |=> !six_bit_port_oe) else $error("port c driven");
  out_region_a: assert property (@(posedge clock) disable iff (!nrst)
    !in_region |=> !ad_oe) else $error("bus driven outside region");
  ram_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
    (cur_ff.addr < pio_pkg::port_space) |=> !ad_oe) else $error("ram area answered");
  read_a_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_act && hit_a |=> ad_oe && ad_out == $past(ia.rd_val)) else $error("bad port a read");
  write_b_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_rise && hit_b |=> ##1 pb_out == $past(cur_ff.data_s2, 2)) else $error("port b write");
  cmd_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_act && hit_cmd |=> !ad_oe) else $error("command read answered");
  reset_in_a: assert property (@(posedge clock)
    $rose(nrst) |-> !pa_oe && !pb_oe && !six_bit_port_oe) else $error("ports not inputs");

  // Read answers for every port; a stale mux value would show here first
  sequence port_rd_s;
    rd_act && (hit_a || hit_b || hit_c);
  endsequence
  sequence port_wr_a_s;
    wr_rise && hit_a;
  endsequence
  sequence port_wr_c_s;
    wr_rise && hit_c;
  endsequence
  port_read_a: assert property (@(posedge clock) disable iff (!nrst)
    port_rd_s |=> ad_oe) else $error("port read not driven");
  bus_idle_a: assert property (@(posedge clock) disable iff (!nrst)
    !rd_act |=> !ad_oe) else $error("bus driven without read");
  read_b_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_act && hit_b |=> ad_out == $past(ib.rd_val)) else $error("bad port b read");
  read_c_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_act && hit_c |=> ad_out == {2'h0, $past(ic.rd_val)}) else $error("bad port c read");
  // Written bytes reach the pins two cycles after the strobe edge is seen
  write_a_a: assert property (@(posedge clock) disable iff (!nrst)
    port_wr_a_s |=> ##1 pa_out == $past(cur_ff.data_s2, 2)) else $error("port a write");
  write_c_a: assert property (@(posedge clock) disable iff (!nrst)
    port_wr_c_s |=> ##1 six_bit_port_out == $past(cur_ff.data_s2[CW-1:0], 2))
    else $error("port c write");
  // Direction follows the stored command one cycle later
  port_b_dir_a: assert property (@(posedge clock) disable iff (!nrst)
    cur_ff.cmd[pio_pkg::cmd_b_bit] |=> pb_oe) else $error("port b not driven");
  port_c_out_a: assert property (@(posedge clock) disable iff (!nrst)
    (cur_ff.cmd[3:2] == pio_pkg::c_out_code) |=> six_bit_port_oe) else $error("port c idle");
endmodule

// ==== testbench/host_bus_model.sv ====
// Host side of the multiplexed external data bus: address phase, then one strobe.
// Assumes the expander samples every bus line on its own 100 MHz clock.
module host_bus_model (
  // Clock
  input wire logic clock,
  // Multiplexed host bus
  output logic ale,
  output logic [7:0] addr_hi,
  output logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe,
  output logic host_write_strobe_line_n,
  output logic host_read_strobe_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hv = 8'h00;
  logic hoe = 1'b1;
  // A released bus shows the device or a changed byte, never the stale one
  assign ad_in = hoe ? hv : (ad_oe ? ad_out : ~hv);
  initial begin
    ale = 1'b0;
    addr_hi = 8'h00;
    host_write_strobe_line_n = 1'b1;
    host_read_strobe_line_n = 1'b1;
  end
  // One access; long phases because the expander syncs every line
  task automatic xfer(input logic [15:0] a, input logic rd, input logic [7:0] d,
                      output logic [7:0] q, output logic oe);
    @(negedge clock);
    ale = 1'b1;
    addr_hi = a[15:8];
    hv = a[7:0];
    hoe = 1'b1;
    repeat (5) @(negedge clock);
    ale = 1'b0;
    repeat (5) @(negedge clock);
    if (rd) begin
      hoe = 1'b0;
      host_read_strobe_line_n = 1'b0;
    end else begin
      hv = d;
      host_write_strobe_line_n = 1'b0;
    end
    repeat (8) @(negedge clock);
    q = ad_in;
    oe = ad_oe;
    host_read_strobe_line_n = 1'b1;
    host_write_strobe_line_n = 1'b1;
    repeat (8) @(negedge clock);
    hoe = 1'b1;
  endtask
endmodule

// ==== testbench/mapped_parallel_port_expander_tb.sv ====
// Self-checking bench for the expander: host accesses through the bus model.
// Assumes pins read back the latch when a port drives, else the bench value.
module mapped_parallel_port_expander_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ale, ad_oe, wr_n, rd_n, pa_oe, pb_oe, six_oe, oe;
  logic [7:0] addr_hi, ad_in, ad_out, pa_in, pa_out, pb_in, pb_out, q;
  logic [5:0] six_in, six_out;
  logic [5:0] six_drv = 6'h3c;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  // Pin level follows whoever drives it
  assign pa_in = pa_oe ? pa_out : 8'h5a;
  assign pb_in = pb_oe ? pb_out : 8'ha5;
  assign six_in = six_oe ? six_out : six_drv;
  host_bus_model i_host_bus_model (.clock(clock), .ale(ale), .addr_hi(addr_hi),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .host_write_strobe_line_n(wr_n),
    .host_read_strobe_line_n(rd_n));
  pio_expander i_pio_expander (.clock(clock), .nrst(nrst), .ale(ale), .addr_hi(addr_hi),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .host_write_strobe_line_n(wr_n),
    .host_read_strobe_line_n(rd_n), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .six_bit_port_in(six_in),
    .six_bit_port_out(six_out), .six_bit_port_oe(six_oe));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic eoe);
    i_host_bus_model.xfer(a, 1'b1, 8'h00, q, oe);
    chk("bus drive", {7'h0, oe}, {7'h0, eoe});
    if (eoe) chk("read data", q, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_host_bus_model.xfer(a, 1'b0, d, q, oe);
  endtask
  task automatic chk_oe(input logic [2:0] e);
    chk("port dirs", {5'h0, pa_oe, pb_oe, six_oe}, {5'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] cmd;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    chk_oe(3'h0);
    // Direction command first; reset already loads 00, so the ports can be read as inputs before it is set
    wr(16'hb800, 8'h00);
    rd(16'hb801, 8'h5a, 1'b1);
    rd(16'hb802, 8'ha5, 1'b1);
    rd(16'hb803, 8'h3c, 1'b1);
    rd(16'hb800, 8'h00, 1'b0);
    rd(16'hb401, 8'h00, 1'b0);
    rd(16'ha801, 8'h00, 1'b0);
    rd(16'hb804, 8'h00, 1'b0);
    // Every documented direction code
    for (int i = 0; i < 8; i++) begin
      cmd = {4'h0, i[2] ? 2'h3 : 2'h0, i[1:0]};
      wr(16'hb800, cmd);
      chk_oe({cmd[0], cmd[1], cmd[2]});
    end
    wr(16'hb800, 8'h07);
    chk_oe(3'h6);
    wr(16'hb800, 8'h0f);
    wr(16'hb801, 8'hc3);
    wr(16'hb802, 8'h3c);
    wr(16'hb803, 8'h2a);
    wr(16'ha801, 8'hff);
    wr(16'hb401, 8'hff);
    wr(16'hb901, 8'hff);
    repeat (6) @(negedge clock);
    chk("port a pins", pa_in, 8'hc3);
    chk("port b pins", pb_in, 8'h3c);
    chk("port c pins", {2'h0, six_in}, 8'h2a);
    rd(16'hb801, 8'hc3, 1'b1);
    wr(16'hb800, 8'h00);
    rd(16'hb801, 8'h5a, 1'b1);
    nrst = 1'b0;
    @(negedge clock);
    chk("latch after reset", pa_out, 8'h00);
    chk_oe(3'h0);
    tally_and_finish();
  end
endmodule
